/* rtl/fpcsr_pkg.sv */
// Constants for the floating-point control and status register block.
// Assumes a single core clock and an AXI4-Lite master for software access.
package fpcsr_pkg;
  // Byte addresses of the 32-bit views
  localparam logic [7:0] FPCSR_LO_ADDR = 8'h00;
  localparam logic [7:0] FPCSR_HI_ADDR = 8'h04;
  localparam logic [7:0] FPCSR_IRQ_STAT_ADDR = 8'h08;
  localparam logic [7:0] FPCSR_IRQ_MASK_ADDR = 8'h0c;
  // Field positions in the 64-bit register
  localparam int FPCSR_SUM_POS = 63;
  localparam int FPCSR_INEXACT_DIS_POS = 62;
  localparam int FPCSR_UNDERFLOW_DIS_POS = 61;
  localparam int FPCSR_UNDER_ZERO_POS = 60;
  localparam int FPCSR_RM_LO_POS = 58;
  localparam int FPCSR_FLAG_LO_POS = 52;
  localparam int FPCSR_TD_LO_POS = 49;
  localparam int FPCSR_NUM_FLAGS = 6;
  // Flag index within the six-bit flag group
  localparam int FPCSR_F_INVALID = 0;
  localparam int FPCSR_F_DIV_ZERO = 1;
  localparam int FPCSR_F_OVERFLOW = 2;
  localparam int FPCSR_F_UNDERFLOW = 3;
  localparam int FPCSR_F_INEXACT = 4;
  localparam int FPCSR_F_INT_OVERFLOW = 5;
  // Reset values
  localparam logic [5:0] FPCSR_FLAGS_RST = 6'h00;
  localparam logic [1:0] FPCSR_RM_RST = 2'h2;
  localparam logic [2:0] FPCSR_TD_RST = 3'h0;
  localparam logic [5:0] FPCSR_MASK_RST = 6'h00;
  // AXI responses
  localparam logic [1:0] FPCSR_RESP_OKAY = 2'h0;
  localparam logic [1:0] FPCSR_RESP_SLVERR = 2'h2;
  typedef enum logic [1:0] {
    FPCSR_RM_CHOP,
    FPCSR_RM_MINUS,
    FPCSR_RM_NEAREST,
    FPCSR_RM_PLUS
  } fpcsr_rm_type;
endpackage

/* rtl/fpcsr_trap_ctl.sv */
// Trap and result qualification for one completing floating operation.
// Assumes exception indications and the result arrive in the same cycle.
`timescale 1ns/100ps
module fpcsr_trap_ctl
  import fpcsr_pkg::*;
(
  input wire logic [5:0] exc,
  input wire logic sw_completion,
  input wire logic dyn_select,
  input wire logic [1:0] static_rm,
  input wire logic [63:0] result_in,
  input wire logic inexact_disable,
  input wire logic underflow_disable,
  input wire logic underflow_zero,
  input wire logic [1:0] dynamic_rounding_field,
  output logic [5:0] trap,
  output logic [63:0] result_out,
  output fpcsr_rm_type rm
);
  logic unf_quiet;
  always_comb begin
    unf_quiet = underflow_disable && underflow_zero && sw_completion;
    trap = exc;
    if (inexact_disable) begin
      trap[FPCSR_F_INEXACT] = 1'b0;
    end
    if (unf_quiet) begin
      trap[FPCSR_F_UNDERFLOW] = 1'b0;
    end
    // Disable bits 51..49 have no input here: those traps always stand
    result_out = result_in;
    if (exc[FPCSR_F_UNDERFLOW] && underflow_zero && underflow_disable) begin
      result_out = 64'h0;
    end
    rm = fpcsr_rm_type'(dyn_select ? dynamic_rounding_field : static_rm);
  end
endmodule // fpcsr_trap_ctl

/* rtl/fpcsr_top.sv */
// Floating-point control and status register with AXI4-Lite access.
// Assumes execution units present one completing operation per cycle.
`timescale 1ns/100ps
module fpcsr_top
  import fpcsr_pkg::*;
(
  input wire logic sys_clk,
  input wire logic rst,
  input wire logic [7:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [7:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic op_valid,
  input wire logic [5:0] op_exc,
  input wire logic op_sw_completion,
  input wire logic op_dyn_select,
  input wire logic [1:0] op_static_rm,
  input wire logic [63:0] op_result,
  output logic res_valid_ff,
  output logic [63:0] res_data_ff,
  output logic [5:0] res_trap_ff,
  output fpcsr_rm_type res_rm_ff,
  output logic irq_ff
);
  // Architectural state of the 64-bit register
  logic [5:0] flags_ff;
  logic inexact_trap_disable_ff;
  logic underflow_trap_disable_ff;
  logic underflow_to_zero_ff;
  logic [1:0] rm_ff;
  logic [2:0] td_ff;
  // Interrupt status and mask
  logic [5:0] irq_stat_ff;
  logic [5:0] irq_mask_ff;
  // Write channel holding registers
  logic aw_held_ff;
  logic w_held_ff;
  logic [7:0] aw_addr_ff;
  logic [31:0] w_data_ff;
  logic [3:0] w_strb_ff;
  // Decodes and next values
  logic do_write;
  logic wr_hi;
  logic wr_irq_stat;
  logic wr_irq_mask;
  logic rd_take;
  logic [5:0] exc_now;
  logic [5:0] trap_c;
  logic [63:0] result_c;
  fpcsr_rm_type rm_c;
  logic [63:0] reg_view;
  logic [31:0] hi_wr;
  logic [5:0] irq_clr;
  logic [5:0] nxt_flags;
  logic [5:0] nxt_irq_stat;
  logic [31:0] nxt_rdata;
  logic [1:0] nxt_rresp;

  // Byte-lane merge keeps unstrobed bytes at their current value
  function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] d,
                                        input logic [3:0] s);
    logic [31:0] r;
    r = old;
    for (int i = 0; i < 4; i++) begin
      if (s[i]) begin
        r[i*8 +: 8] = d[i*8 +: 8];
      end
    end
    return r;
  endfunction

  // Word decode; the two low address bits select nothing
  function automatic logic word_hit(input logic [7:0] a, input logic [7:0] reg_addr);
    return a[7:2] == reg_addr[7:2];
  endfunction

  // Any word beyond the last register answers with an error
  function automatic logic [1:0] resp_for(input logic [7:0] a);
    return (a[7:2] <= FPCSR_IRQ_MASK_ADDR[7:2]) ? FPCSR_RESP_OKAY : FPCSR_RESP_SLVERR;
  endfunction

  assign exc_now = op_valid ? op_exc : 6'h00;
  // reserved bits read zero, summary is live OR of flags, never stored
  assign reg_view = {|flags_ff, inexact_trap_disable_ff, underflow_trap_disable_ff,
                     underflow_to_zero_ff, rm_ff, flags_ff, td_ff, 49'h0};
  // Only one write in flight: the next is not applied while its response waits
  assign do_write = aw_held_ff && w_held_ff && !s_axi_bvalid;
  assign wr_hi = do_write && word_hit(aw_addr_ff, FPCSR_HI_ADDR);
  assign wr_irq_stat = do_write && word_hit(aw_addr_ff, FPCSR_IRQ_STAT_ADDR) && w_strb_ff[0];
  assign wr_irq_mask = do_write && word_hit(aw_addr_ff, FPCSR_IRQ_MASK_ADDR) && w_strb_ff[0];
  assign rd_take = s_axi_arvalid && s_axi_arready;
  assign hi_wr = merge(reg_view[63:32], w_data_ff, w_strb_ff);
  assign irq_clr = wr_irq_stat ? w_data_ff[5:0] : 6'h00;

  fpcsr_trap_ctl i_fpcsr_trap_ctl (
    .exc(exc_now),
    .sw_completion(op_sw_completion),
    .dyn_select(op_dyn_select),
    .static_rm(op_static_rm),
    .result_in(op_result),
    .inexact_disable(inexact_trap_disable_ff),
    .underflow_disable(underflow_trap_disable_ff),
    .underflow_zero(underflow_to_zero_ff),
    .dynamic_rounding_field(rm_ff),
    .trap(trap_c),
    .result_out(result_c),
    .rm(rm_c)
  );

  // Result path registered so every output comes from a flip-flop;
  // this costs one cycle of latency on every completing operation
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      res_valid_ff <= 1'b0;
    end else begin
      res_valid_ff <= op_valid;
    end
  end

  always_ff @(posedge sys_clk) begin
    if (rst) begin
      res_data_ff <= 64'h0;
    end else begin
      res_data_ff <= result_c;
    end
  end

  always_ff @(posedge sys_clk) begin
    if (rst) begin
      res_trap_ff <= 6'h00;
    end else begin
      res_trap_ff <= trap_c;
    end
  end

  always_ff @(posedge sys_clk) begin
    if (rst) begin
      res_rm_ff <= FPCSR_RM_NEAREST;
    end else begin
      res_rm_ff <= rm_c;
    end
  end

  // Write address and data are taken independently, in either order
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      aw_held_ff <= 1'b0;
      aw_addr_ff <= 8'h00;
    end else if (s_axi_awvalid && s_axi_awready) begin
      aw_held_ff <= 1'b1;
      aw_addr_ff <= s_axi_awaddr;
    end else if (do_write) begin
      aw_held_ff <= 1'b0;
    end
  end

  always_ff @(posedge sys_clk) begin
    if (rst) begin
      w_held_ff <= 1'b0;
      w_data_ff <= 32'h0;
      w_strb_ff <= 4'h0;
    end else if (s_axi_wvalid && s_axi_wready) begin
      w_held_ff <= 1'b1;
      w_data_ff <= s_axi_wdata;
      w_strb_ff <= s_axi_wstrb;
    end else if (do_write) begin
      w_held_ff <= 1'b0;
    end
  end

  // Ready drops on the taking edge so a held item is never taken twice
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      s_axi_awready <= 1'b0;
    end else begin
      s_axi_awready <= !aw_held_ff && !(s_axi_awvalid && s_axi_awready) && !s_axi_bvalid;
    end
  end

  always_ff @(posedge sys_clk) begin
    if (rst) begin
      s_axi_wready <= 1'b0;
    end else begin
      s_axi_wready <= !w_held_ff && !(s_axi_wvalid && s_axi_wready) && !s_axi_bvalid;
    end
  end

  always_ff @(posedge sys_clk) begin
    if (rst) begin
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= FPCSR_RESP_OKAY;
    end else if (do_write) begin
      s_axi_bvalid <= 1'b1;
      s_axi_bresp <= resp_for(aw_addr_ff);
    end else if (s_axi_bready) begin
      s_axi_bvalid <= 1'b0;
    end
  end

  // Flags: hardware set wins over software clear in the same cycle,
  // so an event is never lost to a clear that software issued blind
  always_comb begin
    nxt_flags = flags_ff;
    if (wr_hi) begin
      nxt_flags = hi_wr[FPCSR_FLAG_LO_POS-32 +: FPCSR_NUM_FLAGS];
    end
    nxt_flags = nxt_flags | exc_now;
  end

  always_ff @(posedge sys_clk) begin
    if (rst) begin
      flags_ff <= FPCSR_FLAGS_RST;
    end else begin
      flags_ff <= nxt_flags;
    end
  end

  // Control fields live in the high word; the low word holds nothing
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      inexact_trap_disable_ff <= 1'b0;
    end else if (wr_hi) begin
      inexact_trap_disable_ff <= hi_wr[FPCSR_INEXACT_DIS_POS-32];
    end
  end

  always_ff @(posedge sys_clk) begin
    if (rst) begin
      underflow_trap_disable_ff <= 1'b0;
    end else if (wr_hi) begin
      underflow_trap_disable_ff <= hi_wr[FPCSR_UNDERFLOW_DIS_POS-32];
    end
  end

  always_ff @(posedge sys_clk) begin
    if (rst) begin
      underflow_to_zero_ff <= 1'b0;
    end else if (wr_hi) begin
      underflow_to_zero_ff <= hi_wr[FPCSR_UNDER_ZERO_POS-32];
    end
  end

  always_ff @(posedge sys_clk) begin
    if (rst) begin
      rm_ff <= FPCSR_RM_RST;
    end else if (wr_hi) begin
      rm_ff <= hi_wr[FPCSR_RM_LO_POS-32 +: 2];
    end
  end

  // Stored and read back only: these three disables never reach the trap logic
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      td_ff <= FPCSR_TD_RST;
    end else if (wr_hi) begin
      td_ff <= hi_wr[FPCSR_TD_LO_POS-32 +: 3];
    end
  end

  // Interrupt status: sticky, write one to clear, set wins
  assign nxt_irq_stat = (irq_stat_ff & ~irq_clr) | exc_now;

  always_ff @(posedge sys_clk) begin
    if (rst) begin
      irq_stat_ff <= 6'h00;
    end else begin
      irq_stat_ff <= nxt_irq_stat;
    end
  end

  always_ff @(posedge sys_clk) begin
    if (rst) begin
      irq_mask_ff <= FPCSR_MASK_RST;
    end else if (wr_irq_mask) begin
      irq_mask_ff <= w_data_ff[5:0];
    end
  end

  // Registered from registered status: the line follows an event by two cycles
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      irq_ff <= 1'b0;
    end else begin
      irq_ff <= |(irq_stat_ff & irq_mask_ff);
    end
  end

  // Read data chosen from the address in the cycle it is taken
  always_comb begin
    case (s_axi_araddr[7:2])
      FPCSR_LO_ADDR[7:2]: nxt_rdata = reg_view[31:0];
      FPCSR_HI_ADDR[7:2]: nxt_rdata = reg_view[63:32];
      FPCSR_IRQ_STAT_ADDR[7:2]: nxt_rdata = {26'h0, irq_stat_ff};
      FPCSR_IRQ_MASK_ADDR[7:2]: nxt_rdata = {26'h0, irq_mask_ff};
      default: nxt_rdata = 32'h0;
    endcase
    nxt_rresp = resp_for(s_axi_araddr);
  end

  // Read channel: one cycle from address acceptance to data;
  // the address is refused again until the data has been taken
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      s_axi_arready <= 1'b0;
    end else if (rd_take) begin
      s_axi_arready <= 1'b0;
    end else if (!s_axi_rvalid) begin
      s_axi_arready <= 1'b1;
    end
  end

  always_ff @(posedge sys_clk) begin
    if (rst) begin
      s_axi_rvalid <= 1'b0;
    end else if (rd_take) begin
      s_axi_rvalid <= 1'b1;
    end else if (s_axi_rvalid && s_axi_rready) begin
      s_axi_rvalid <= 1'b0;
    end
  end

  always_ff @(posedge sys_clk) begin
    if (rst) begin
      s_axi_rdata <= 32'h0;
      s_axi_rresp <= FPCSR_RESP_OKAY;
    end else if (rd_take) begin
      s_axi_rdata <= nxt_rdata;
      s_axi_rresp <= nxt_rresp;
    end
  end
endmodule // fpcsr_top

/* dv/fpcsr_chk.sv */
// Port assertions for the floating-point control and status block.
// Assumes it is bound to fpcsr_top with one clock and a synchronous reset.
`timescale 1ns/100ps
module fpcsr_chk
  import fpcsr_pkg::*;
(
  input wire logic sys_clk,
  input wire logic rst,
  input wire logic [7:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  input wire logic s_axi_arready,
  input wire logic [31:0] s_axi_rdata,
  input wire logic s_axi_rvalid,
  input wire logic op_valid,
  input wire logic [5:0] op_exc,
  input wire logic op_sw_completion,
  input wire logic op_dyn_select,
  input wire logic [1:0] op_static_rm,
  input wire logic [63:0] op_result,
  input wire logic res_valid_ff,
  input wire logic [63:0] res_data_ff,
  input wire logic [5:0] res_trap_ff,
  input wire fpcsr_rm_type res_rm_ff
);
  default clocking @(posedge sys_clk); endclocking
  default disable iff (rst);
  AST_RES_VALID: assert property (op_valid |=> res_valid_ff)
    else $error("result valid missing");
  AST_RM_STATIC: assert property (op_valid && !op_dyn_select |=>
    res_rm_ff == $past(op_static_rm)) else $error("static rounding not used");
  AST_TRAP_PASS: assert property (op_valid |=>
    res_trap_ff[2:0] == $past(op_exc[2:0])) else $error("unsupported disable acted");
  AST_IOV_TRAP: assert property (op_valid |=>
    res_trap_ff[5] == $past(op_exc[5])) else $error("integer overflow trap wrong");
  AST_TRAP_SUBSET: assert property (op_valid |=>
    (res_trap_ff & ~$past(op_exc)) == 6'h00) else $error("trap without exception");
  AST_UNF_NOQUAL: assert property (op_valid && op_exc[3] && !op_sw_completion |=>
    res_trap_ff[3]) else $error("underflow trap suppressed without qualifier");
  AST_DATA_PASS: assert property (op_valid && !op_exc[3] |=>
    res_data_ff == $past(op_result)) else $error("result altered without underflow");
  AST_LO_ZERO: assert property (s_axi_arvalid && s_axi_arready && s_axi_araddr == 8'h00 |=>
    s_axi_rvalid && s_axi_rdata == 32'h0000_0000) else $error("reserved word not zero");
endmodule // fpcsr_chk

bind fpcsr_top fpcsr_chk i_fpcsr_chk (.sys_clk, .rst, .s_axi_araddr, .s_axi_arvalid,
  .s_axi_arready, .s_axi_rdata, .s_axi_rvalid, .op_valid, .op_exc, .op_sw_completion,
  .op_dyn_select, .op_static_rm, .op_result, .res_valid_ff, .res_data_ff, .res_trap_ff,
  .res_rm_ff);

/* dv/fpcsr_tb.sv */
// Self-checking bench for the floating-point control and status block.
// Assumes an AXI4-Lite slave at 0x00..0x0c and one op per cycle at most.
`timescale 1ns/100ps
module fpcsr_tb
  import fpcsr_pkg::*;
;
  logic sys_clk = 1'b0, rst = 1'b1, s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0;
  logic s_axi_bready = 1'b0, s_axi_arvalid = 1'b0, s_axi_rready = 1'b0, op_valid = 1'b0;
  logic op_sw_completion = 1'b0, op_dyn_select = 1'b0;
  logic [7:0] s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00;
  logic [31:0] s_axi_wdata = 32'h0000_0000;
  logic [3:0] s_axi_wstrb = 4'hf;
  logic [5:0] op_exc = 6'h00;
  logic [1:0] op_static_rm = 2'h0;
  logic [63:0] op_result = 64'h0;
  logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  logic res_valid_ff, irq_ff;
  logic [1:0] s_axi_bresp, s_axi_rresp, rsp;
  logic [31:0] s_axi_rdata, rv;
  logic [63:0] res_data_ff;
  logic [5:0] res_trap_ff;
  fpcsr_rm_type res_rm_ff;
  int bad_count = 0, checks = 0;

  fpcsr_top i_fpcsr_top (.sys_clk, .rst, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready,
    .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp,
    .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready,
    .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .op_valid, .op_exc,
    .op_sw_completion, .op_dyn_select, .op_static_rm, .op_result, .res_valid_ff,
    .res_data_ff, .res_trap_ff, .res_rm_ff, .irq_ff);

  always #20 sys_clk = ~sys_clk;

  task test_done;
    $display("checks %0d mismatches %0d", checks, bad_count);
    if (bad_count == 0 && checks > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask

  task chk(input string nm, input logic [63:0] seen, input logic [63:0] exp);
    checks++;
    if (seen !== exp) begin
      bad_count++;
      $display("mismatch %s expected %h seen %h", nm, exp, seen);
    end
  endtask

  // Both channels offered together; each released at its own handshake edge
  task wr(input logic [7:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge sys_clk);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    while (n < 40) begin
      @(posedge sys_clk);
      n++;
      if (s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wready) s_axi_wvalid <= 1'b0;
      if (s_axi_bvalid) break;
    end
    if (n >= 40) begin
      bad_count++;
      test_done;
    end else begin
      rsp = s_axi_bresp;
      s_axi_bready <= 1'b0;
    end
  endtask

  task rd(input logic [7:0] a);
    int n;
    n = 0;
    @(posedge sys_clk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    while (n < 40) begin
      @(posedge sys_clk);
      n++;
      if (s_axi_arready) s_axi_arvalid <= 1'b0;
      if (s_axi_rvalid) break;
    end
    if (n >= 40) begin
      bad_count++;
      test_done;
    end else begin
      rv = s_axi_rdata;
      rsp = s_axi_rresp;
      s_axi_rready <= 1'b0;
    end
  endtask

  // One completing operation; returns once its registered results have landed
  task op(input logic [5:0] e, input logic sw, input logic dy, input logic [1:0] sr,
          input logic [63:0] r);
    @(posedge sys_clk);
    op_valid <= 1'b1;
    op_exc <= e;
    op_sw_completion <= sw;
    op_dyn_select <= dy;
    op_static_rm <= sr;
    op_result <= r;
    @(posedge sys_clk);
    op_valid <= 1'b0;
    op_exc <= 6'h00;
    #1;
  endtask

  task t_reset;
    rd(8'h04); chk("hi_rst", rv, 32'h0800_0000);
    rd(8'h10); chk("unmapped", rsp, FPCSR_RESP_SLVERR);
    chk("unmapped_data", rv, 32'h0);
    wr(8'h00, 32'hffff_ffff);
    chk("wr_ok", rsp, FPCSR_RESP_OKAY);
    rd(8'h00); chk("lo", rv, 32'h0);
    wr(8'h10, 32'h0000_0000);
    chk("wr_unmapped", rsp, FPCSR_RESP_SLVERR);
  endtask

  task t_flags;
    logic [5:0] acc;
    acc = 6'h00;
    for (int i = 0; i < 6; i++) begin
      op(6'h01 << i, 1'b0, 1'b0, 2'h0, 64'h0);
      acc = acc | (6'h01 << i);
      rd(8'h04); chk("flags", rv[25:20], acc);
      chk("summary", rv[31], 1'b1);
    end
    op(6'h00, 1'b0, 1'b0, 2'h0, 64'h0);
    rd(8'h04); chk("sticky", rv[25:20], 6'h3f);
    // Summary written as one must still read the now-clear flags
    wr(8'h04, 32'hfc0f_ffff); rd(8'h04); chk("ctl", rv, 32'h7c0e_0000);
  endtask

  task t_traps;
    op(6'h3f, 1'b1, 1'b1, 2'h0, 64'h1234);
    chk("trap_q", res_trap_ff, 6'h27);
    chk("zero", res_data_ff, 64'h0);
    chk("rm_dyn", res_rm_ff, 2'h3);
    op(6'h3f, 1'b0, 1'b0, 2'h1, 64'h1234); chk("trap_nq", res_trap_ff, 6'h2f);
    chk("rm_static", res_rm_ff, 2'h1);
    for (int m = 0; m < 4; m++) begin
      wr(8'h04, m << 26);
      op(6'h3f, 1'b1, 1'b1, 2'h0, 64'h55);
      chk("rm", res_rm_ff, m);
      chk("trap_all", res_trap_ff, 6'h3f);
      chk("no_zeroing", res_data_ff, 64'h55);
    end
    wr(8'h04, 32'h1000_0000);
    op(6'h08, 1'b1, 1'b0, 2'h0, 64'h77); chk("underflow_to_zero_only", res_data_ff, 64'h77);
    chk("unf_trap_kept", res_trap_ff, 6'h08);
  endtask

  // Byte strobes: only the strobed lane of the high word changes
  task t_strobe;
    op(6'h30, 1'b0, 1'b0, 2'h0, 64'h0);
    s_axi_wstrb <= 4'h4;
    wr(8'h04, 32'h0000_0000);
    s_axi_wstrb <= 4'hf;
    rd(8'h04);
    chk("strobe", rv, 32'h9300_0000);
  endtask

  // Reset again in mid-run; state must return to its reset values
  task t_rerst;
    @(posedge sys_clk);
    rst <= 1'b1;
    repeat (8) @(posedge sys_clk);
    rst <= 1'b0;
    rd(8'h04);
    chk("hi_rerst", rv, 32'h0800_0000);
  endtask

  task t_irq;
    wr(8'h08, 32'h3f); wr(8'h0c, 32'h04);
    op(6'h04, 1'b0, 1'b0, 2'h0, 64'h0);
    @(posedge sys_clk); #1; chk("irq_on", irq_ff, 1'b1);
    wr(8'h08, 32'h04);
    @(posedge sys_clk); #1; chk("irq_clr", irq_ff, 1'b0);
    rd(8'h08); chk("stat_clr", rv[5:0], 6'h00);
    wr(8'h0c, 32'h0);
    op(6'h04, 1'b0, 1'b0, 2'h0, 64'h0);
    repeat (2) @(posedge sys_clk);
    #1; chk("irq_masked", irq_ff, 1'b0);
    rd(8'h08); chk("stat_set", rv[5:0], 6'h04);
  endtask

  initial begin
    repeat (8) @(posedge sys_clk);
    rst <= 1'b0;
    t_reset;
    t_flags;
    t_traps;
    t_irq;
    t_strobe;
    t_rerst;
    test_done;
  end
endmodule // fpcsr_tb
